/* design/swb_cfg.svh */
// Overview of operation
// R1: write-byte is its command code plus one data byte, then sent on the line.
// R2: write-byte arriving while busy is not acknowledged and is discarded.
// R3: read-byte arriving while busy is not acknowledged and is ignored.
// R4: write-byte line activity starts within 262.5ns after the data byte completes.
// R5: write-byte finishes within eight slot periods plus 262.5ns.
// R6: bytes go onto the line least significant bit first.
// R7: busy flag stays set for the eight slots of either byte command.
// R8: an accepted byte command points the read pointer at status.
// R9: write-byte honours speed, strong pullup and active pullup settings.
// R10: read-byte has no parameter; eight slots fill the read-data register.
// R11: every read-byte slot is a write-one slot whose sampled level is the bit.
// R12: read-byte finishes within eight slot periods plus 262.5ns; a full receive queue keeps it busy until the queue has room.
// R13: read-byte line activity starts within 262.5ns after the command.
// R14: host selects read-data with the pointer, then reads the byte.
// R15: bit zero makes a write-zero slot, bit one a write-one/read slot.
// R16: each slot samples the line at the read sample point.
// R17: first sampled slot lands in bit 0 of the received byte.
`ifndef SWB_CFG_SVH
`define SWB_CFG_SVH

`define SWB_CLK_NS 100
`define SWB_CLK_PS 100000
`define SWB_CYC(ns) (((ns) + `SWB_CLK_NS - 1) / `SWB_CLK_NS)
`define SWB_ACT_MAX_PS 262500
`define SWB_ACT_MAX_CYC (`SWB_ACT_MAX_PS / `SWB_CLK_PS)

`define SWB_SLOT_STD_NS 70000
`define SWB_W0L_STD_NS 60000
`define SWB_W1L_STD_NS 6000
`define SWB_MSR_STD_NS 15000
`define SWB_SLOT_OD_NS 10000
`define SWB_W0L_OD_NS 8000
`define SWB_W1L_OD_NS 1000
`define SWB_MSR_OD_NS 2000
`define SWB_CNT_W 12

`define SWB_CMD_WRITE 8'ha5
`define SWB_CMD_READ 8'h96
`define SWB_BITS_LAST 4'h7
`define SWB_BYTE_ONES 8'hff

`define SWB_OFS_CMD 8'h00
`define SWB_OFS_CFG 8'h04
`define SWB_OFS_PTR 8'h08
`define SWB_OFS_DATA 8'h0c

`define SWB_CFG_SPEED 0
`define SWB_CFG_SPU 1
`define SWB_CFG_APU 2
`define SWB_CFG_RST 3'h0
`define SWB_FIFO_DEPTH 8
`define SWB_FIFO_AW 3

`endif

/* design/swb_pkg.sv */
package swb_pkg;
  typedef enum logic [2:0] {
    ST_IDLE = 3'h1,
    ST_SLOT = 3'h2,
    ST_STORE = 3'h4
  } swb_st_t;
endpackage

/* design/swb_fifo.sv */
`timescale 1ns/10ps
`include "swb_cfg.svh"
module swb_fifo #(
  parameter int W = 8,
  parameter int D = `SWB_FIFO_DEPTH,
  parameter int AW = `SWB_FIFO_AW
) (
  input wire logic clk,
  input wire logic rst_n,
  input wire logic in_valid,
  output logic in_ready,
  input wire logic [W-1:0] in_data,
  output logic out_valid,
  input wire logic out_ready,
  output logic [W-1:0] out_data
);
  logic [W-1:0] mem [D];
  logic [AW-1:0] wp_r, rp_r;
  logic [AW:0] cnt_r;
  logic push, pop;

  // the count is one bit wider than the pointers so that a full queue is told from an empty one
  assign in_ready = (cnt_r != (AW + 1)'(D));
  assign out_valid = (cnt_r != '0);
  assign out_data = mem[rp_r];
  assign push = in_valid && in_ready;
  assign pop = out_valid && out_ready;

  always_ff @(posedge clk) begin
    if (push) begin
      mem[wp_r] <= in_data;
    end
  end

  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      wp_r <= '0;
      rp_r <= '0;
      cnt_r <= '0;
    end else begin
      if (push) begin
        wp_r <= (wp_r == AW'(D - 1)) ? '0 : wp_r + 1'b1;
      end
      if (pop) begin
        rp_r <= (rp_r == AW'(D - 1)) ? '0 : rp_r + 1'b1;
      end
      cnt_r <= cnt_r + {AW'(0), push} - {AW'(0), pop};
    end
  end
endmodule // swb_fifo

/* design/swb_slot.sv */
`timescale 1ns/10ps
`include "swb_cfg.svh"
module swb_slot (
  input wire logic clk,
  input wire logic rst_n,
  input wire logic start,
  input wire logic tx_bit,
  input wire logic speed,
  input wire logic line_s,
  output logic done,
  output logic rx_bit_r,
  output logic drive_n_r
);
  logic [`SWB_CNT_W-1:0] cnt_r;
  logic act_r, bit_r;

  // pick the standard or overdrive figure for one slot phase
  function automatic logic [`SWB_CNT_W-1:0] cyc(input logic od, input int s, input int o);
    return od ? `SWB_CNT_W'(`SWB_CYC(o)) : `SWB_CNT_W'(`SWB_CYC(s));
  endfunction

  logic [`SWB_CNT_W-1:0] len, low, msr;
  assign len = cyc(speed, `SWB_SLOT_STD_NS, `SWB_SLOT_OD_NS);
  assign msr = cyc(speed, `SWB_MSR_STD_NS, `SWB_MSR_OD_NS);
  assign low = bit_r ? cyc(speed, `SWB_W1L_STD_NS, `SWB_W1L_OD_NS)
                     : cyc(speed, `SWB_W0L_STD_NS, `SWB_W0L_OD_NS); // R15
  assign done = act_r && (cnt_r == len - 1'b1);

  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      act_r <= 1'b0;
      cnt_r <= '0;
      bit_r <= 1'b1;
    end else if (start) begin
      act_r <= 1'b1;
      cnt_r <= '0;
      bit_r <= tx_bit;
    end else if (done) begin
      act_r <= 1'b0;
    end else if (act_r) begin
      cnt_r <= cnt_r + 1'b1;
    end
  end

  // open drain: pull low only for the slot's low time
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      drive_n_r <= 1'b1;
    end else if (start) begin
      drive_n_r <= 1'b0;
    end else if (act_r && cnt_r == low - 1'b1) begin
      drive_n_r <= 1'b1;
    end
  end

  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      rx_bit_r <= 1'b1;
    end else if (act_r && cnt_r == msr) begin
      rx_bit_r <= line_s; // R16
    end
  end
endmodule // swb_slot

/* design/swb_top.sv */
`timescale 1ns/10ps
`include "swb_cfg.svh"
module swb_top (
  input wire logic clk,
  input wire logic rstn,
  input wire logic hsel,
  input wire logic [31:0] haddr,
  input wire logic [1:0] htrans,
  input wire logic hwrite,
  input wire logic [2:0] hsize,
  input wire logic [31:0] hwdata,
  input wire logic hready,
  output logic hreadyout,
  output logic [31:0] hrdata,
  output logic hresp,
  input wire logic line_i,
  output logic line_o,
  output logic line_oe_n,
  output logic spu_oe_n,
  output logic apu_on
);
  localparam int ACT_MAX = `SWB_ACT_MAX_CYC;

  logic rst_s1_r, rst_s2_r, rst_n;
  logic line_s1_r, line_s2_r;
  logic wr_pend_r;
  logic [7:0] wr_addr_r;
  logic [31:0] hrdata_r;
  logic hreadyout_r, hresp_r;
  logic [2:0] cfg_r;
  logic rptr_r, nack_r;
  swb_pkg::swb_st_t st_r;
  logic [7:0] shift_r;
  logic [3:0] bitn_r;
  logic is_rd_r, go_r;
  logic spu_oe_n_r, apu_on_r;
  logic ap_valid, cmd_we, byte_cmd, acc_wr, acc_rd, acc;
  logic slot_go, slot_done, slot_rx, slot_drv_n;
  logic fifo_in_ready, fifo_out_valid, fifo_pop;
  logic [7:0] fifo_out;
  logic [31:0] rd_val;
  logic [7:0] code;
  logic tx_next;
  logic pull_ok;

  // full decode: anything outside the four words is unmapped
  function automatic logic sel(input logic [31:0] a, input logic [7:0] ofs);
    return (a[31:8] == 24'h0) && (a[7:0] == ofs);
  endfunction

  always_ff @(posedge clk or negedge rstn) begin
    if (!rstn) begin
      rst_s1_r <= 1'b0;
      rst_s2_r <= 1'b0;
    end else begin
      rst_s1_r <= 1'b1;
      rst_s2_r <= rst_s1_r;
    end
  end
  assign rst_n = rst_s2_r;

  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      line_s1_r <= 1'b1;
      line_s2_r <= 1'b1;
    end else begin
      line_s1_r <= line_i;
      line_s2_r <= line_s1_r;
    end
  end

  // ahb-lite slave: always ready, always okay
  assign ap_valid = hsel && htrans[1] && hready;
  assign code = hwdata[7:0];
  assign cmd_we = wr_pend_r && (wr_addr_r == `SWB_OFS_CMD);
  assign byte_cmd = (code == `SWB_CMD_WRITE) || (code == `SWB_CMD_READ);
  assign acc_wr = cmd_we && (code == `SWB_CMD_WRITE) && (st_r == swb_pkg::ST_IDLE); // R1
  assign acc_rd = cmd_we && (code == `SWB_CMD_READ) && (st_r == swb_pkg::ST_IDLE); // R10
  assign acc = acc_wr || acc_rd;
  assign fifo_pop = ap_valid && !hwrite && sel(haddr, `SWB_OFS_DATA) && rptr_r;

  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      wr_pend_r <= 1'b0;
      wr_addr_r <= 8'h0;
      hreadyout_r <= 1'b1;
      hresp_r <= 1'b0;
    end else begin
      wr_pend_r <= ap_valid && hwrite && (haddr[31:8] == 24'h0);
      wr_addr_r <= haddr[7:0];
      hreadyout_r <= 1'b1;
      hresp_r <= 1'b0;
    end
  end

  always_comb begin
    rd_val = 32'h0;
    if (sel(haddr, `SWB_OFS_CFG)) begin
      rd_val = {29'h0, cfg_r};
    end else if (sel(haddr, `SWB_OFS_PTR)) begin
      rd_val = {31'h0, rptr_r};
    end else if (sel(haddr, `SWB_OFS_DATA)) begin
      // an empty queue reads as zero rather than a stale slot
      rd_val = rptr_r ? {24'h0, (fifo_out_valid ? fifo_out : 8'h0)}
                      : {28'h0, !fifo_in_ready, fifo_out_valid, nack_r,
                         st_r != swb_pkg::ST_IDLE};
    end
  end

  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      hrdata_r <= 32'h0;
    end else if (ap_valid && !hwrite) begin
      hrdata_r <= rd_val;
    end
  end

  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      cfg_r <= `SWB_CFG_RST;
    end else if (wr_pend_r && wr_addr_r == `SWB_OFS_CFG) begin
      cfg_r <= hwdata[2:0];
    end
  end

  // an accepted command wins over a pointer write in the same cycle
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      rptr_r <= 1'b0;
    end else if (acc) begin
      rptr_r <= 1'b0; // R8
    end else if (wr_pend_r && wr_addr_r == `SWB_OFS_PTR) begin
      rptr_r <= hwdata[0]; // R14
    end
  end

  // refused command leaves a sticky flag; only the next accepted one clears it
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      nack_r <= 1'b0;
    end else if (cmd_we && byte_cmd && st_r != swb_pkg::ST_IDLE) begin
      nack_r <= 1'b1; // R2 R3
    end else if (acc) begin
      nack_r <= 1'b0;
    end
  end

  // byte engine; next slot starts in the very cycle the previous one ends
  assign slot_go = go_r || (st_r == swb_pkg::ST_SLOT && slot_done
                            && bitn_r != `SWB_BITS_LAST);
  // a continuing slot starts on the edge that shifts, so it takes the next bit up
  assign tx_next = go_r ? shift_r[0] : shift_r[1]; // R6 R15

  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      st_r <= swb_pkg::ST_IDLE;
      shift_r <= 8'h0;
      bitn_r <= 4'h0;
      is_rd_r <= 1'b0;
      go_r <= 1'b0;
    end else begin
      go_r <= 1'b0;
      case (st_r)
        swb_pkg::ST_IDLE: begin
          if (acc) begin
            // full byte is in hand before the first slot, so lsb can lead
            shift_r <= acc_rd ? `SWB_BYTE_ONES : hwdata[15:8]; // R6 R11
            is_rd_r <= acc_rd;
            bitn_r <= 4'h0;
            go_r <= 1'b1; // R4 R13
            st_r <= swb_pkg::ST_SLOT; // R7
          end
        end
        swb_pkg::ST_SLOT: begin
          if (slot_done) begin
            shift_r <= {slot_rx, shift_r[7:1]}; // R17
            bitn_r <= bitn_r + 1'b1;
            if (bitn_r == `SWB_BITS_LAST) begin
              st_r <= is_rd_r ? swb_pkg::ST_STORE : swb_pkg::ST_IDLE; // R5 R12
            end
          end
        end
        swb_pkg::ST_STORE: begin
          // a full receive queue stalls here, keeping busy set
          if (fifo_in_ready) begin
            st_r <= swb_pkg::ST_IDLE;
          end
        end
        default: begin
          st_r <= swb_pkg::ST_IDLE;
        end
      endcase
    end
  end

  swb_slot u_slot (
    .clk(clk),
    .rst_n(rst_n),
    .start(slot_go),
    .tx_bit(tx_next),
    .speed(cfg_r[`SWB_CFG_SPEED]),
    .line_s(line_s2_r),
    .done(slot_done),
    .rx_bit_r(slot_rx),
    .drive_n_r(slot_drv_n)
  );

  swb_fifo #(.W(8), .D(`SWB_FIFO_DEPTH), .AW(`SWB_FIFO_AW)) u_fifo (
    .clk(clk),
    .rst_n(rst_n),
    .in_valid(st_r == swb_pkg::ST_STORE),
    .in_ready(fifo_in_ready),
    .in_data(shift_r),
    .out_valid(fifo_out_valid),
    .out_ready(fifo_pop),
    .out_data(fifo_out)
  );

  // pullups act only while the line is released inside a slot,
  // and never on an edge that starts a slot, so they cannot fight the pull-down
  assign pull_ok = st_r == swb_pkg::ST_SLOT && slot_drv_n && !slot_go;

  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      spu_oe_n_r <= 1'b1;
      apu_on_r <= 1'b0;
    end else begin
      spu_oe_n_r <= !(cfg_r[`SWB_CFG_SPU] && pull_ok && !is_rd_r); // R9
      apu_on_r <= cfg_r[`SWB_CFG_APU] && pull_ok; // R9
    end
  end

  assign hreadyout = hreadyout_r;
  assign hresp = hresp_r;
  assign hrdata = hrdata_r;
  assign line_o = 1'b0;
  assign line_oe_n = slot_drv_n;
  assign spu_oe_n = spu_oe_n_r;
  assign apu_on = apu_on_r;

  default clocking cb @(posedge clk); endclocking
  default disable iff (!rst_n);

  sequence s_accept;
    acc && st_r == swb_pkg::ST_IDLE;
  endsequence

  sequence s_first_low;
    ##[1:ACT_MAX] !line_oe_n;
  endsequence

  // a byte command that lands while the engine runs
  sequence s_refused;
    cmd_we && byte_cmd && st_r != swb_pkg::ST_IDLE;
  endsequence

  sequence s_last_slot;
    st_r == swb_pkg::ST_SLOT && slot_done && bitn_r == `SWB_BITS_LAST;
  endsequence

  a_refuse_busy: assert property (s_refused |=> nack_r && $stable(is_rd_r)) // R2
    else $error("busy command not refused");
  a_refuse_keep: assert property ( // R3
    s_refused ##0 st_r == swb_pkg::ST_SLOT && !slot_done |=> $stable(bitn_r))
    else $error("busy command disturbed the byte");
  a_nack_clear: assert property (acc |=> !nack_r) // R2 R3
    else $error("nack not cleared by accept");
  a_start_fast: assert property (s_accept |-> s_first_low) // R4
    else $error("line activity late");
  a_read_start: assert property (acc_rd |-> ##[1:ACT_MAX] !line_oe_n) // R13
    else $error("read activity late");
  a_go_pulse: assert property (go_r |-> slot_go ##1 !go_r && !line_oe_n) // R4
    else $error("first slot not launched");
  a_ptr_status: assert property (acc |=> !rptr_r) // R8
    else $error("pointer not at status");
  a_lsb_first: assert property ( // R6
    acc_wr |=> ##1 (u_slot.bit_r == $past(hwdata[8], 2)))
    else $error("first slot not lsb");
  a_read_ones: assert property (is_rd_r && slot_go |=> u_slot.bit_r) // R11
    else $error("read slot not write-one");
  a_busy_held: assert property ( // R7
    st_r == swb_pkg::ST_SLOT && bitn_r != `SWB_BITS_LAST |=> st_r == swb_pkg::ST_SLOT)
    else $error("busy dropped early");
  a_store_stall: assert property ( // R7
    st_r == swb_pkg::ST_STORE && !fifo_in_ready |=> st_r == swb_pkg::ST_STORE)
    else $error("busy dropped on full queue");
  a_bit_count: assert property ( // R5 R12
    st_r == swb_pkg::ST_SLOT |-> bitn_r <= `SWB_BITS_LAST)
    else $error("slot count overrun");
  a_write_end: assert property (s_last_slot ##0 !is_rd_r |=> st_r == swb_pkg::ST_IDLE) // R5
    else $error("write byte overran");
  a_read_end: assert property (s_last_slot ##0 is_rd_r |=> st_r == swb_pkg::ST_STORE) // R12
    else $error("read byte overran");
  a_rx_store: assert property ( // R10
    st_r == swb_pkg::ST_STORE && fifo_in_ready |=> st_r == swb_pkg::ST_IDLE && fifo_out_valid)
    else $error("read byte not stored");
  a_empty_zero: assert property ( // R10
    ap_valid && !hwrite && sel(haddr, `SWB_OFS_DATA) && rptr_r && !fifo_out_valid
    |=> hrdata == 32'h0)
    else $error("empty queue read not zero");
  a_spu_read: assert property (is_rd_r |=> spu_oe_n) // R9
    else $error("strong pullup in read");
  // the pull-down and either pullup are never on together
  a_spu_clash: assert property (!line_oe_n |-> spu_oe_n) // R9
    else $error("strong pullup fights pull-down");
  a_apu_clash: assert property (!line_oe_n |-> !apu_on) // R9
    else $error("active pullup fights pull-down");
endmodule // swb_top

/* tb/swb_line_model.sv */
`timescale 1ns/10ps
module swb_line_model (
  input wire logic line,
  input wire logic od,
  input wire logic [7:0] tx_byte,
  output logic pull,
  output logic [7:0] rx_byte,
  output logic [2:0] idx
);
  initial begin
    pull = 1'b0;
    rx_byte = 8'h00;
    idx = 3'h0;
  end
  // a zero reply holds the line well past the master's sample point
  always @(negedge line) begin
    pull = !tx_byte[idx];
    #(od ? 4000 : 30000);
    rx_byte = {line, rx_byte[7:1]};
    pull = 1'b0;
    idx = idx + 3'h1;
  end
endmodule // swb_line_model

/* tb/tb.sv */
`timescale 1ns/10ps
`include "swb_cfg.svh"
module tb;
  logic clk, rstn, hsel, hwrite, hready, od;
  logic [31:0] haddr, hwdata, hrdata, rd;
  logic [1:0] htrans;
  logic [2:0] hsize, idx;
  logic [7:0] tx_byte, rx_byte;
  logic hreadyout, hresp, line_o, line_oe_n, spu_oe_n, apu_on, pull;
  int err_total, tests_run, cyc, t0, spu_cyc, apu_cyc;
  // pull-up: the line is high unless someone pulls it down
  wire line_w = !(!line_oe_n || pull);
  assign hready = hreadyout;

  swb_top i_dut (.clk(clk), .rstn(rstn), .hsel(hsel), .haddr(haddr), .htrans(htrans),
    .hwrite(hwrite), .hsize(hsize), .hwdata(hwdata), .hready(hready),
    .hreadyout(hreadyout), .hrdata(hrdata), .hresp(hresp), .line_i(line_w),
    .line_o(line_o), .line_oe_n(line_oe_n), .spu_oe_n(spu_oe_n), .apu_on(apu_on));
  swb_line_model i_slave (.line(line_w), .od(od), .tx_byte(tx_byte), .pull(pull),
    .rx_byte(rx_byte), .idx(idx));

  initial begin
    clk = 1'b0;
    forever #50 clk = ~clk;
  end
  always @(posedge clk) cyc <= cyc + 1;
  always @(posedge clk) if (spu_oe_n === 1'b0) spu_cyc <= cyc;
  always @(posedge clk) if (apu_on === 1'b1) apu_cyc <= cyc;

  task automatic tally_and_finish();
    $display("checks %0d mismatches %0d", tests_run, err_total);
    if (err_total == 0 && tests_run > 0) begin
      $display("DONE - PASS");
    end else begin
      $display("DONE - FAIL");
    end
    $finish;
  endtask

  task automatic check(input string what, input logic [31:0] got, input logic [31:0] exp);
    tests_run++;
    if (got !== exp) begin
      err_total++;
      $display("MISMATCH %s expected %h seen %h", what, exp, got);
    end
  endtask

  task automatic wait_rdy();
    int n;
    n = 0;
    while (hreadyout !== 1'b1) begin
      @(posedge clk);
      n++;
      if (n > 50) begin
        err_total++;
        tally_and_finish();
      end
    end
  endtask

  // one single word transfer; the address phase stands until hready is seen
  task automatic bus(input logic wr, input logic [7:0] a, input logic [31:0] wd);
    hsel <= 1'b1;
    haddr <= {24'h0, a};
    htrans <= 2'h2;
    hwrite <= wr;
    @(posedge clk);
    wait_rdy();
    hsel <= 1'b0;
    htrans <= 2'h0;
    hwdata <= wd;
    @(posedge clk);
    wait_rdy();
    rd = hrdata;
  endtask

  task automatic rdchk(input logic [7:0] a, input logic [31:0] exp, input string what);
    bus(1'b0, a, 32'h0);
    check(what, rd, exp);
  endtask

  // looked at on falling edges so the launching edge never races the look
  task automatic chk_start();
    int n;
    n = 0;
    while (line_oe_n !== 1'b0 && n < 6) begin
      @(negedge clk);
      n++;
    end
    check("line start", 32'(n), 32'd2);
    @(posedge clk);
  endtask

  // polls status; the span since t0 must fall in lo..hi cycles
  task automatic wait_idle(input int lo, input int hi);
    int n;
    n = 0;
    rd = 32'h1;
    while (rd[0] !== 1'b0) begin
      bus(1'b0, `SWB_OFS_DATA, 32'h0);
      n++;
      if (n > 4000) begin
        err_total++;
        tally_and_finish();
      end
    end
    check("busy span", 32'(cyc - t0 >= lo && cyc - t0 <= hi), 32'h1);
  endtask

  task automatic cmd(input logic [7:0] code, input logic [7:0] b);
    bus(1'b1, `SWB_OFS_CMD, {16'h0, b, code});
    t0 = cyc;
  endtask

  initial begin
    rstn = 1'b0;
    hsel = 1'b0;
    haddr = 32'h0;
    htrans = 2'h0;
    hwrite = 1'b0;
    hsize = 3'h2;
    hwdata = 32'h0;
    od = 1'b0;
    tx_byte = 8'hff;
    err_total = 0;
    tests_run = 0;
    cyc = 0;
    spu_cyc = 0;
    apu_cyc = 0;
    repeat (2) @(posedge clk);
    check("reset pins", {27'h0, hresp, line_o, line_oe_n, spu_oe_n, apu_on}, 32'h6);
    rstn <= 1'b1;
    repeat (3) @(posedge clk);
    rdchk(`SWB_OFS_CFG, 32'h0, "cfg reset");
    // write byte, with both byte commands refused while it runs
    bus(1'b1, `SWB_OFS_PTR, 32'h1);
    cmd(`SWB_CMD_WRITE, 8'h3c);
    chk_start();
    rdchk(`SWB_OFS_PTR, 32'h0, "pointer");
    bus(1'b1, `SWB_OFS_CMD, {16'h0, 8'h5a, `SWB_CMD_WRITE});
    bus(1'b1, `SWB_OFS_CMD, {24'h0, `SWB_CMD_READ});
    wait_idle(5600, 5610);
    check("tx byte", {24'h0, rx_byte}, 32'h3c);
    rdchk(`SWB_OFS_DATA, 32'h2, "status nack");
    $display("test write done");
    // read byte at standard speed
    tx_byte = 8'hb4;
    cmd(`SWB_CMD_READ, 8'h00);
    chk_start();
    wait_idle(5600, 5610);
    rdchk(`SWB_OFS_DATA, 32'h4, "status rx");
    bus(1'b1, `SWB_OFS_PTR, 32'h1);
    rdchk(`SWB_OFS_DATA, 32'hb4, "rx byte");
    rdchk(`SWB_OFS_DATA, 32'h0, "rx empty");
    bus(1'b1, `SWB_OFS_PTR, 32'h0);
    $display("test read done");
    // overdrive write with both pullups enabled
    tx_byte = 8'hff;
    od = 1'b1;
    bus(1'b1, `SWB_OFS_CFG, 32'h7);
    rdchk(`SWB_OFS_CFG, 32'h7, "cfg");
    check("apu idle", {31'h0, apu_on}, 32'h0);
    cmd(`SWB_CMD_WRITE, 8'h81);
    wait_idle(800, 810);
    check("tx od", {24'h0, rx_byte}, 32'h81);
    check("spu on", 32'(spu_cyc > t0), 32'h1);
    check("apu on", 32'(apu_cyc > t0), 32'h1);
    bus(1'b1, 8'h10, 32'hffff);
    rdchk(8'h10, 32'h0, "unmapped");
    $display("test config done");
    // fill the receive buffer, stall a ninth read, then drain
    bus(1'b1, `SWB_OFS_CFG, 32'h1);
    tx_byte = 8'h6e;
    for (int i = 0; i < 8; i++) begin
      cmd(`SWB_CMD_READ, 8'h00);
      wait_idle(800, 810);
    end
    rdchk(`SWB_OFS_DATA, 32'hc, "status full");
    cmd(`SWB_CMD_READ, 8'h00);
    repeat (1200) @(posedge clk);
    rdchk(`SWB_OFS_DATA, 32'hd, "status stall");
    bus(1'b1, `SWB_OFS_CMD, {24'h0, `SWB_CMD_READ});
    rdchk(`SWB_OFS_DATA, 32'hf, "status refused read");
    bus(1'b1, `SWB_OFS_PTR, 32'h1);
    for (int i = 0; i < 8; i++) rdchk(`SWB_OFS_DATA, 32'h6e, "fifo byte");
    bus(1'b1, `SWB_OFS_PTR, 32'h0);
    t0 = cyc;
    wait_idle(0, 2000);
    bus(1'b1, `SWB_OFS_PTR, 32'h1);
    rdchk(`SWB_OFS_DATA, 32'h6e, "last byte");
    rdchk(`SWB_OFS_DATA, 32'h0, "fifo empty");
    $display("test buffer done");
    tally_and_finish();
  end
endmodule // tb
